// ---- hdl/rro_defs.svh ----
// Purpose: constants for the reset-outcome identify word block
// Assumes: included by the block's package and module
// Notes:   register byte address is four times the register index
`ifndef RRO_DEFS_SVH
`define RRO_DEFS_SVH

// ****************************************
// register indices and bus layout
// ****************************************
`define RRO_IDX_W        8
`define RRO_IDX_LSB      2
`define RRO_IDX_PWR      8'h5b
`define RRO_IDX_PWREV    8'h5c
`define RRO_IDX_OUTCOME  8'h5d
`define RRO_IDX_CTRL     8'h5e
`define RRO_RESP_OKAY    2'h0
`define RRO_RESP_SLVERR  2'h2

// ****************************************
// outcome word fields
// ****************************************
`define RRO_B_TOP        15
`define RRO_B_VALID      14
`define RRO_TOP_VAL      2'h1
`define RRO_B_CABLE      13
`define RRO_B_D1_PDIAG   11
`define RRO_F_D1_METH_HI 10
`define RRO_F_D1_METH_LO 9
`define RRO_B_D1_ONE     8
`define RRO_B_D0_RESP    6
`define RRO_B_D0_DASP    5
`define RRO_B_D0_PDIAG   4
`define RRO_B_D0_DIAG    3
`define RRO_F_D0_METH_HI 2
`define RRO_F_D0_METH_LO 1
`define RRO_B_D0_ONE     0
`define RRO_LOW_W        13
`define RRO_LOW_RST      13'h0000
`define RRO_CTRL_RESP    0
`define RRO_CTRL_RST     1'h1

`endif

// ---- hdl/rro_pkg.sv ----
// Purpose: shared types for the reset-outcome identify word block
// Assumes: rro_defs.svh holds the register and field numbers; the enum codes are set here
// Notes:   types only
`include "rro_defs.svh"
package rro_pkg;
  // capture state around the device's hardware reset
  typedef enum logic [0:0] {
    RRO_ST_RUN  = 1'b0,
    RRO_ST_CAPT = 1'b1
  } rro_state_e;
  // number-selection method codes, 00 never reported
  typedef enum logic [1:0] {
    RRO_M_RSVD   = 2'b00,
    RRO_M_JUMPER = 2'b01,
    RRO_M_CSEL   = 2'b10,
    RRO_M_OTHER  = 2'b11
  } rro_meth_e;
endpackage

// ---- hdl/rro_outcome_regs.sv ----
// Purpose: builds the reset-outcome identify word and serves it on AXI4-Lite
// Assumes: one 20 MHz clock, pins are asynchronous to it
// Notes:   the low thirteen bits move only while the reset is running
//
// Operation
// - bits 12..0 hold still except during hardware reset
// - bit 15 reads zero, bit 14 reads one
// - bit 13 follows cable-id high and low threshold sensing
// - device 0 forces bits 12..8 to zero
// - device 1 bit 11 tells whether it asserted passed-diagnostics
// - device 1 bits 10..9 tell how its number was chosen
// - method 01 for jumper, 10 for cable select
// - method 11 for other or unknown method
// - device 1 reports bit 8 as one
// - device 1 forces bits 7..0 to zero
// - device 0 bit 6 tells whether it answers for device 1
// - device 0 records device-present seen from device 1
// - device 0 records passed-diagnostics seen from device 1
// - device 0 bits 2..1 use the same method encoding
`timescale 1ns/1ns
`include "rro_defs.svh"

module rro_outcome_regs
  import rro_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  // axi4-lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  // axi4-lite read data
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // device logic, same clock
  input  wire logic              hw_reset_busy,
  input  wire logic              self_diag_pass,
  input  wire logic [15:0]       pwr_level,
  input  wire logic [15:0]       pw_revision,
  // cable pins, asynchronous
  input  wire logic              cblid_above_hi,
  input  wire logic              cblid_below_lo,
  input  wire logic              dev_is_one,
  input  wire logic              num_by_jumper,
  input  wire logic              num_by_csel,
  input  wire logic              pdiag_asserted,
  input  wire logic              dasp_asserted
);

  // ****************************************
  // helpers
  // ****************************************

  // method field from the sensing pins; never the reserved code
  function automatic rro_meth_e meth_code(input logic jmp,
                                          input logic csl);
    meth_code = (jmp && !csl) ? RRO_M_JUMPER :
                (csl && !jmp) ? RRO_M_CSEL : RRO_M_OTHER;
  endfunction

  // register index from a byte address; upper bits must be zero
  function automatic logic [`RRO_IDX_W-1:0] idx_of(
      input logic [ADDR_W-1:0] a);
    idx_of = a[`RRO_IDX_LSB +: `RRO_IDX_W];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [`RRO_IDX_W-1:0] i;
    i = idx_of(a);
    // bits above the index would otherwise alias onto real registers
    mapped = ((a >> (`RRO_IDX_LSB + `RRO_IDX_W)) == '0) &&
             (a[`RRO_IDX_LSB-1:0] == '0) &&
             (i == `RRO_IDX_PWR || i == `RRO_IDX_PWREV ||
              i == `RRO_IDX_OUTCOME || i == `RRO_IDX_CTRL);
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_reg;
  logic [NPIN-1:0] pin_sync_reg;

  assign pin_raw = {dasp_asserted, pdiag_asserted, num_by_csel,
                    num_by_jumper, dev_is_one, cblid_below_lo,
                    cblid_above_hi};

  // two flops each; only the second stage is read by logic
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_meta_reg[g] <= 1'b0;
          pin_sync_reg[g] <= 1'b0;
        end else begin
          pin_meta_reg[g] <= pin_raw[g];
          pin_sync_reg[g] <= pin_meta_reg[g];
        end
      end
    end
  endgenerate

  logic cbl_hi_s;
  logic cbl_lo_s;
  logic dev1_s;
  logic jmp_s;
  logic csel_s;
  logic pdiag_s;
  logic dasp_s;
  assign {dasp_s, pdiag_s, csel_s, jmp_s, dev1_s, cbl_lo_s,
          cbl_hi_s} = pin_sync_reg;

  // ****************************************
  // reset capture
  // ****************************************
  rro_state_e state_reg;
  logic       ctrl_resp_reg;
  logic       pdiag_seen_reg;
  logic       pdiag_seen_next;
  logic       dasp_seen_reg;
  logic       dasp_seen_next;
  logic       cable_reg;
  logic [`RRO_LOW_W-1:0] low_reg;
  logic [`RRO_LOW_W-1:0] low_next;
  logic       entering;

  assign entering = (state_reg == RRO_ST_RUN) && hw_reset_busy;

  // state follows the reset; marks the first cycle of each reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RRO_ST_RUN;
    end else begin
      case (state_reg)
        RRO_ST_RUN:  state_reg <= hw_reset_busy ? RRO_ST_CAPT : RRO_ST_RUN;
        RRO_ST_CAPT: state_reg <= hw_reset_busy ? RRO_ST_CAPT : RRO_ST_RUN;
        default:     state_reg <= RRO_ST_RUN;
      endcase
    end
  end

  // sticky sightings: a pin seen on the clearing cycle still counts
  always_comb begin
    pdiag_seen_next = (entering ? 1'b0 : pdiag_seen_reg) | pdiag_s;
    dasp_seen_next  = (entering ? 1'b0 : dasp_seen_reg) | dasp_s;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pdiag_seen_reg <= 1'b0;
      dasp_seen_reg  <= 1'b0;
    end else if (hw_reset_busy) begin
      pdiag_seen_reg <= pdiag_seen_next;
      dasp_seen_reg  <= dasp_seen_next;
    end
  end

  // low thirteen bits of the word, laid out per device role
  always_comb begin
    low_next = `RRO_LOW_RST;
    if (dev1_s) begin
      // device 0 half stays zero on device 1
      low_next[`RRO_B_D1_PDIAG] = pdiag_seen_next;
      low_next[`RRO_F_D1_METH_HI:`RRO_F_D1_METH_LO] =
        meth_code(jmp_s, csel_s);
      low_next[`RRO_B_D1_ONE] = 1'b1;
    end else begin
      // device 1 half stays zero on device 0
      low_next[`RRO_B_D0_RESP]  = ctrl_resp_reg;
      low_next[`RRO_B_D0_DASP]  = dasp_seen_next;
      low_next[`RRO_B_D0_PDIAG] = pdiag_seen_next;
      low_next[`RRO_B_D0_DIAG]  = self_diag_pass;
      low_next[`RRO_F_D0_METH_HI:`RRO_F_D0_METH_LO] =
        meth_code(jmp_s, csel_s);
      low_next[`RRO_B_D0_ONE] = 1'b1;
    end
  end

  // only a running reset may move these bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_reg <= `RRO_LOW_RST;
    end else if (hw_reset_busy) begin
      low_reg <= low_next;
    end
  end

  // cable level with hysteresis: between thresholds it holds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cable_reg <= 1'b0;
    end else if (cbl_hi_s && !cbl_lo_s) begin
      cable_reg <= 1'b1;
    end else if (cbl_lo_s && !cbl_hi_s) begin
      cable_reg <= 1'b0;
    end
  end

  logic [15:0] outcome_word;
  assign outcome_word = {`RRO_TOP_VAL, cable_reg, low_reg};

  // ****************************************
  // axi4-lite write side
  // ****************************************
  logic                  aw_have_reg;
  logic [`RRO_IDX_W-1:0] aw_idx_reg;
  logic                  aw_ok_reg;
  logic                  w_have_reg;
  logic                  w_bit_reg;
  logic                  w_lane0_reg;

  assign awready = !aw_have_reg && !bvalid;
  assign wready  = !w_have_reg && !bvalid;

  // address and data land in either order; answer once both are in
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_reg <= 1'b0;
      aw_idx_reg  <= '0;
      aw_ok_reg   <= 1'b0;
      w_have_reg  <= 1'b0;
      w_bit_reg   <= 1'b0;
      w_lane0_reg <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= `RRO_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have_reg <= 1'b1;
        aw_idx_reg  <= idx_of(awaddr);
        aw_ok_reg   <= mapped(awaddr);
      end
      if (wvalid && wready) begin
        w_have_reg  <= 1'b1;
        w_bit_reg   <= wdata[`RRO_CTRL_RESP];
        w_lane0_reg <= wstrb[0];
      end
      if (aw_have_reg && w_have_reg) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid      <= 1'b1;
        // read-only words and holes answer with an error
        bresp <= (aw_ok_reg && aw_idx_reg == `RRO_IDX_CTRL) ?
                 `RRO_RESP_OKAY : `RRO_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // control bit: whether device 0 answers while device 1 is selected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_resp_reg <= `RRO_CTRL_RST;
    end else if (aw_have_reg && w_have_reg && aw_ok_reg &&
                 aw_idx_reg == `RRO_IDX_CTRL && w_lane0_reg) begin
      ctrl_resp_reg <= w_bit_reg;
    end
  end

  // ****************************************
  // axi4-lite read side
  // ****************************************
  logic [`RRO_IDX_W-1:0] rd_idx_reg;

  assign arready = !rvalid;

  // one read at a time; data is registered at acceptance
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid     <= 1'b0;
      rdata      <= '0;
      rresp      <= `RRO_RESP_OKAY;
      rd_idx_reg <= '0;
    end else if (arvalid && arready) begin
      rvalid     <= 1'b1;
      rd_idx_reg <= idx_of(araddr);
      rresp      <= mapped(araddr) ? `RRO_RESP_OKAY : `RRO_RESP_SLVERR;
      rdata      <= '0;
      if (mapped(araddr)) begin
        case (idx_of(araddr))
          `RRO_IDX_PWR:     rdata[15:0] <= pwr_level;
          `RRO_IDX_PWREV:   rdata[15:0] <= pw_revision;
          `RRO_IDX_OUTCOME: rdata[15:0] <= outcome_word;
          `RRO_IDX_CTRL:    rdata[1:0]  <= {hw_reset_busy, ctrl_resp_reg};
          default:          rdata       <= '0;
        endcase
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_low_stable: assert property (@(posedge clk)
    disable iff (!rst_n) !hw_reset_busy |=> $stable(low_reg))
    else $error("outcome low bits moved outside reset");
  a_top_bits: assert property (@(posedge clk)
    disable iff (!rst_n) (rvalid && rresp == `RRO_RESP_OKAY && rd_idx_reg ==
    `RRO_IDX_OUTCOME) |-> rdata[`RRO_B_TOP:`RRO_B_VALID] == `RRO_TOP_VAL)
    else $error("outcome top bits wrong");
  a_cable_high: assert property (@(posedge clk)
    disable iff (!rst_n) (cbl_hi_s && !cbl_lo_s) |=> cable_reg)
    else $error("cable bit not set above high threshold");
  a_dev0_upper: assert property (@(posedge clk)
    disable iff (!rst_n) (hw_reset_busy && !dev1_s)
    |=> low_reg[`RRO_LOW_W-1:`RRO_B_D1_ONE] == '0)
    else $error("device 0 left device 1 field nonzero");
  a_dev1_pdiag: assert property (@(posedge clk)
    disable iff (!rst_n) (hw_reset_busy && dev1_s && pdiag_s)
    |=> low_reg[`RRO_B_D1_PDIAG])
    else $error("device 1 passed-diag bit missed");
  a_meth_nonzero: assert property (@(posedge clk)
    disable iff (!rst_n) low_reg[`RRO_B_D1_ONE] |->
    low_reg[`RRO_F_D1_METH_HI:`RRO_F_D1_METH_LO] != RRO_M_RSVD)
    else $error("reserved method code reported");
  a_meth_jumper: assert property (@(posedge clk)
    disable iff (!rst_n) (hw_reset_busy && dev1_s && jmp_s && !csel_s)
    |=> low_reg[`RRO_F_D1_METH_HI:`RRO_F_D1_METH_LO] == RRO_M_JUMPER)
    else $error("jumper method code wrong");
  a_meth_other: assert property (@(posedge clk)
    disable iff (!rst_n) (hw_reset_busy && !dev1_s && jmp_s == csel_s)
    |=> low_reg[`RRO_F_D0_METH_HI:`RRO_F_D0_METH_LO] == RRO_M_OTHER)
    else $error("unknown method code wrong");
  a_dev1_one: assert property (@(posedge clk)
    disable iff (!rst_n) (hw_reset_busy && dev1_s) |=> low_reg[`RRO_B_D1_ONE]
    && low_reg[`RRO_B_D1_ONE-1:`RRO_B_D0_ONE] == '0)
    else $error("device 1 field layout wrong");
  a_dev0_resp: assert property (@(posedge clk)
    disable iff (!rst_n) (hw_reset_busy && !dev1_s)
    |=> low_reg[`RRO_B_D0_RESP] == $past(ctrl_resp_reg))
    else $error("respond bit does not follow control");
  a_dasp_seen: assert property (@(posedge clk)
    disable iff (!rst_n) (hw_reset_busy && !dev1_s && dasp_s)
    ##1 (hw_reset_busy && !dev1_s)[*2] |=> low_reg[`RRO_B_D0_DASP])
    else $error("device-present sighting lost");
  a_dev0_pdiag: assert property (@(posedge clk)
    disable iff (!rst_n) (hw_reset_busy && !dev1_s && pdiag_s)
    |=> low_reg[`RRO_B_D0_PDIAG])
    else $error("passed-diag sighting lost");
  a_self_diag: assert property (@(posedge clk)
    disable iff (!rst_n) (hw_reset_busy && !dev1_s)
    |=> low_reg[`RRO_B_D0_DIAG] == $past(self_diag_pass))
    else $error("own diagnostics bit wrong");
endmodule

// ---- sim/rro_host_model.sv ----
// Purpose: host side master that reads the identify words over AXI4-Lite
// Assumes: the bench hands over one command at a time
// Notes:   a taken payload is scrambled so stale values never look valid
`timescale 1ns/1ns

module rro_host_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // command from the bench
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [11:0] adr,
  input  wire logic [31:0] wd,
  output logic             done,
  // axi4-lite master side
  output logic [11:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [11:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic        rvalid,
  output logic             rready
);
  logic hs;

  // **********
  // one transfer per command, handshakes sampled at the rising edge
  // **********
  initial begin
    {done, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    forever begin
      @(posedge clk);
      done <= 1'b0;
      // never ask while the device is still held in reset
      if (go && rst_n) begin
        hs = 1'b0;
        if (wr) begin
          awaddr  <= adr;
          wdata   <= wd;
          wstrb   <= 4'hf;
          awvalid <= 1'b1;
          wvalid  <= 1'b1;
          bready  <= 1'b1;
          while (!hs) begin
            @(posedge clk);
            if (awvalid && awready) begin
              awvalid <= 1'b0;
              awaddr  <= ~awaddr;
            end
            if (wvalid && wready) begin
              wvalid <= 1'b0;
              wdata  <= ~wdata;
            end
            hs = bvalid;
          end
          bready <= 1'b0;
        end else begin
          araddr  <= adr;
          arvalid <= 1'b1;
          rready  <= 1'b1;
          while (!hs) begin
            @(posedge clk);
            if (arvalid && arready) begin
              arvalid <= 1'b0;
              araddr  <= ~araddr;
            end
            hs = rvalid;
          end
          rready <= 1'b0;
        end
        done <= 1'b1;
      end
    end
  end
endmodule

// ---- sim/rro_outcome_regs_test.sv ----
// Purpose: self-checking bench for the reset-outcome identify word
// Assumes: host model performs every bus transfer
// Notes:   expected results queue up, a monitor compares on each answer
`timescale 1ns/1ns
`include "rro_defs.svh"

module rro_outcome_regs_test
  import rro_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        busy;
  logic        diag;
  logic        go;
  logic        wr;
  logic        done;
  logic        cab;
  logic        rsp;
  logic [6:0]  pin;
  logic [7:0]  lfsr;
  logic [12:0] low;
  logic [15:0] pwr;
  logic [15:0] pwrev;
  logic [11:0] adr;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic [31:0] wd;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [33:0] exp_q[$];
  int          num_errors;
  int          samples_checked;

  // pins: above, below, dev1, jumper, csel, pdiag, dasp
  rro_outcome_regs u_rro_outcome_regs (
    .clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .hw_reset_busy(busy),
    .self_diag_pass(diag), .pwr_level(pwr), .pw_revision(pwrev),
    .cblid_above_hi(pin[6]), .cblid_below_lo(pin[5]), .dev_is_one(pin[4]),
    .num_by_jumper(pin[3]), .num_by_csel(pin[2]),
    .pdiag_asserted(pin[1]), .dasp_asserted(pin[0]));

  rro_host_model u_rro_host_model (
    .clk, .rst_n, .go, .wr, .adr, .wd, .done, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rvalid, .rready);

  // **********
  // helpers
  // **********
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // low thirteen bits as the reporting device must form them
  function automatic logic [12:0] low_of(input logic [6:0] p,
                                         input logic r, input logic g);
    logic [1:0]  m;
    logic [12:0] v;
    m = (p[3] && !p[2]) ? RRO_M_JUMPER :
        (p[2] && !p[3]) ? RRO_M_CSEL : RRO_M_OTHER;
    v = 13'h0000;
    if (p[4]) begin
      v[11:8] = {p[1], m, 1'b1};
    end else begin
      v[6:0] = {r, p[0], p[1], g, m, 1'b1};
    end
    return v;
  endfunction

  // cable level holds when neither threshold is cleanly crossed
  function automatic logic cab_of(input logic [6:0] p, input logic c);
    if (p[6] && !p[5]) return 1'b1;
    if (p[5] && !p[6]) return 1'b0;
    return c;
  endfunction

  task automatic check(input logic [33:0] got, input logic [33:0] want);
    samples_checked++;
    if (got !== want) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, got, want);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hand one command to the host model, note its expected answer
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [33:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge clk);
    go  <= 1'b1;
    wr  <= w;
    adr <= a;
    wd  <= d;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    while (!done && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (!done) begin
      num_errors++;
      $display("Error at %0t: bus transfer hung", $time);
      finish_test();
    end
  endtask

  // **********
  // clock, monitor and watchdog
  // **********
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // answers are settled mid-cycle, one handshake each
  always @(negedge clk) begin
    if (bvalid && bready) check({bresp, 32'h0}, exp_q.pop_front());
    if (rvalid && rready) check({rresp, rdata}, exp_q.pop_front());
  end

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  // **********
  // main sequence
  // **********
  initial begin
    logic [6:0] p;
    {rst_n, busy, diag, go, wr, cab} = 6'h00;
    pin   = 7'h00;
    adr   = 12'h000;
    wd    = 32'h0;
    pwr   = 16'h0000;
    pwrev = 16'h0000;
    lfsr  = 8'h5c;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 12'h178, 32'h0, {2'h0, 32'h1});
    bus(1'b0, 12'h174, 32'h0, {2'h0, 32'h4000});
    bus(1'b1, 12'h174, 32'h0, {`RRO_RESP_SLVERR, 32'h0});
    bus(1'b0, 12'h000, 32'h0, {`RRO_RESP_SLVERR, 32'h0});
    // upper address bits and a misaligned byte must not alias the word
    bus(1'b0, 12'h574, 32'h0, {`RRO_RESP_SLVERR, 32'h0});
    bus(1'b0, 12'h175, 32'h0, {`RRO_RESP_SLVERR, 32'h0});
    for (int i = 0; i < 16; i++) begin
      lfsr = lfsr_next(lfsr);
      p = {lfsr[7:6], i[2], i[1:0], lfsr[1:0]};
      rsp = i[3];
      @(posedge clk);
      pin   <= p;
      diag  <= lfsr[2];
      pwr   <= {lfsr, ~lfsr};
      pwrev <= {~lfsr, lfsr};
      bus(1'b1, 12'h178, {31'h0, rsp}, {2'h0, 32'h0});
      bus(1'b0, 12'h16c, 32'h0, {2'h0, 16'h0, lfsr, ~lfsr});
      bus(1'b0, 12'h170, 32'h0, {2'h0, 16'h0, ~lfsr, lfsr});
      cab = cab_of(p, cab);
      low = low_of(p, rsp, lfsr[2]);
      // a device reset spanning a control read
      @(posedge clk);
      busy <= 1'b1;
      bus(1'b0, 12'h178, 32'h0, {2'h0, 30'h0, 1'b1, rsp});
      @(posedge clk);
      busy <= 1'b0;
      repeat (3) @(posedge clk);
      bus(1'b0, 12'h174, 32'h0, {2'h0, 16'h0, 2'b01, cab, low});
      // pins move outside reset: only the cable bit may follow
      lfsr = lfsr_next(lfsr);
      @(posedge clk);
      pin  <= lfsr[6:0];
      diag <= ~diag;
      cab = cab_of(lfsr[6:0], cab);
      repeat (4) @(posedge clk);
      bus(1'b0, 12'h174, 32'h0, {2'h0, 16'h0, 2'b01, cab, low});
    end
    // a second reset mid-run: control and low bits return to reset values
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cab = cab_of(pin, 1'b0);
    bus(1'b0, 12'h178, 32'h0, {2'h0, 32'h1});
    bus(1'b0, 12'h174, 32'h0, {2'h0, 16'h0, 2'b01, cab, 13'h0000});
    finish_test();
  end
endmodule
